// ==== common/ffmd_pkg.sv ====
// Package for the freefall/motion event detector: offsets, fields, resets
package ffmd_pkg;
  // Register offsets on the device register port
  localparam logic [7:0] FFMD_ADDR_CONFIG = 8'h15;
  localparam logic [7:0] FFMD_ADDR_SOURCE = 8'h16;
  // Configuration field positions
  localparam int FFMD_CFG_LATCH = 7;
  localparam int FFMD_CFG_ANY   = 6;
  localparam int FFMD_CFG_ZEN   = 5;
  localparam int FFMD_CFG_YEN   = 4;
  localparam int FFMD_CFG_XEN   = 3;
  // Source field positions
  localparam int FFMD_SRC_HIT   = 7;
  localparam int FFMD_SRC_ZOVER = 5;
  localparam int FFMD_SRC_ZSIGN = 4;
  localparam int FFMD_SRC_YOVER = 3;
  localparam int FFMD_SRC_YSIGN = 2;
  localparam int FFMD_SRC_XOVER = 1;
  localparam int FFMD_SRC_XSIGN = 0;
  // Reset values and widths
  localparam logic [7:0] FFMD_CFG_RESET = 8'h00;
  localparam logic [7:0] FFMD_SRC_RESET = 8'h00;
  localparam int FFMD_THS_W  = 7;
  localparam int FFMD_CNT_W  = 8;
  localparam int FFMD_AXES   = 3;
  // Threshold step in milli-g per LSB
  localparam int FFMD_THS_MG_PER_LSB = 63;

  // Signed sample of all three axes, index 0 = X, 1 = Y, 2 = Z
  typedef struct packed {
    logic signed [13:0] z;
    logic signed [13:0] y;
    logic signed [13:0] x;
  } ffmd_sample_t;

  // Register port access
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ffmd_reg_req_t;
endpackage : ffmd_pkg

// ==== hdl/ffmd_detector.sv ====
// Freefall/motion event detector with debounce, source flags and latch modes
// Contract
// - any_axis_combine 0 selects freefall, 1 selects motion; config bit 6.
// - All three axis enables cleared disables detection; no events raised.
// - Config: latch bit 7, combine bit 6, Z/Y/X enables bits 5..3; reset 0.
// - Motion: any enabled axis magnitude strictly above trip_level.
// - Freefall: all enabled axis magnitudes at or below trip_level.
// - combined_hit (source bit 7) sets only after debounce completes.
// - Unlatched, clear mode 0: hit clears only after counter decrements down.
// - Unlatched, clear mode 1: hit clears at once; re-set needs full delay.
// - Unlatched freefall: source read leaves combined_hit unchanged.
// - Unlatched motion: source read clears nothing, counter untouched.
// - Unlatched: axis flags follow raw comparison of enabled axes.
// - Latched freefall: hit holds until read; read clears hit and counter.
// - Latched motion: read clears all source bits and the counter.
// - Latched freefall: axis flags captured when combined_hit sets.
// - Latched motion: axis flags hold while hit set until read.
// - Latch on: fresh axis results blocked while event held.
// - Axis flags read zero when their enable bit is zero.
// - Source: hit bit 7, Z/Y/X event then sign; sign 1 means negative g.
// - Interrupt output is hit gated by enable and routing settings.
// - Debounce counter saturates at debounce_target; hit when reached.
// - Clear mode 0: counter decrements by one per false sample to zero.
// - One trip_level step is 0.063 g.
`timescale 1ns/1ps
`default_nettype none
module ffmd_detector
  import ffmd_pkg::*;
#(
  parameter int SAMPLE_W = 14,
  parameter int G_SHIFT  = 6
) (
  input  wire logic                  clock_i,
  input  wire logic                  rst_n_i,
  input  wire ffmd_reg_req_t         reg_req_i,
  output logic [7:0]                 reg_rdata_o,
  input  wire logic                  sample_valid_i,
  input  wire ffmd_sample_t          sample_i,
  input  wire logic [FFMD_THS_W-1:0] trip_level_i,
  input  wire logic                  debounce_clear_mode_i,
  input  wire logic [FFMD_CNT_W-1:0] debounce_target_i,
  input  wire logic                  irq_enable_detect_i,
  input  wire logic                  irq_route_detect_i,
  output logic                       irq_pin1_o,
  output logic                       irq_pin2_o
);

  logic [7:0]            cfg_r,   cfg_nxt;
  logic [7:0]            src_r,   src_nxt;
  logic [FFMD_CNT_W-1:0] cnt_r,   cnt_nxt;
  logic [7:0]            rdata_r, rdata_nxt;
  logic                  irq1_r,  irq1_nxt;
  logic                  irq2_r,  irq2_nxt;

  logic [FFMD_AXES-1:0] axis_en;
  logic [FFMD_AXES-1:0] axis_over;
  logic [FFMD_AXES-1:0] axis_neg;
  logic [FFMD_AXES-1:0] axis_flag;
  logic [FFMD_AXES-1:0] axis_sign;
  logic                 latch_on_event;
  logic                 any_axis_combine;
  logic                 any_enabled;
  logic                 cond;
  logic                 src_read;
  logic [5:0]           live_flags;

  assign latch_on_event   = cfg_r[FFMD_CFG_LATCH];
  assign any_axis_combine = cfg_r[FFMD_CFG_ANY];
  assign axis_en = {cfg_r[FFMD_CFG_ZEN], cfg_r[FFMD_CFG_YEN], cfg_r[FFMD_CFG_XEN]};
  assign any_enabled = |axis_en;
  assign src_read = reg_req_i.rd && (reg_req_i.addr == FFMD_ADDR_SOURCE);

  // Per-axis magnitude compare; sample LSB scaled so one trip step is 0.063 g
  for (genvar a = 0; a < FFMD_AXES; a++) begin : g_axis
    logic signed [SAMPLE_W-1:0] s;
    logic [SAMPLE_W-1:0]        mag;
    logic [SAMPLE_W-1:0]        lvl;
    assign s   = (a == 0) ? sample_i.x : (a == 1) ? sample_i.y : sample_i.z;
    assign mag = s[SAMPLE_W-1] ? SAMPLE_W'(-s) : SAMPLE_W'(s);
    assign lvl = SAMPLE_W'({trip_level_i, {G_SHIFT{1'b0}}});
    assign axis_over[a] = mag > lvl;
    assign axis_neg[a]  = s[SAMPLE_W-1];
    // Disabled axes report zero in both flags
    assign axis_flag[a] = axis_en[a] & axis_over[a];
    assign axis_sign[a] = axis_en[a] & axis_over[a] & axis_neg[a];
  end

  // Combine: OR of highs for motion, AND of lows over enabled axes for freefall
  always_comb begin
    if (!any_enabled) begin
      cond = 1'b0;
    end else if (any_axis_combine) begin
      cond = |(axis_en & axis_over);
    end else begin
      cond = &(~axis_en | ~axis_over);
    end
  end

  assign live_flags = {axis_flag[2], axis_sign[2], axis_flag[1], axis_sign[1],
                       axis_flag[0], axis_sign[0]};

  // Config register write and read data mux
  always_comb begin
    cfg_nxt   = cfg_r;
    rdata_nxt = rdata_r;
    if (reg_req_i.wr && reg_req_i.addr == FFMD_ADDR_CONFIG) begin
      cfg_nxt = {reg_req_i.wdata[7:3], 3'h0};
    end
    if (reg_req_i.rd) begin
      case (reg_req_i.addr)
        FFMD_ADDR_CONFIG: rdata_nxt = cfg_r;
        FFMD_ADDR_SOURCE: rdata_nxt = src_r;
        default:          rdata_nxt = 8'h00;
      endcase
    end
  end

  // Debounce counter and source flags
  always_comb begin
    logic hit_nxt;
    logic hit_now;
    hit_now = src_r[FFMD_SRC_HIT];
    hit_nxt = hit_now;
    cnt_nxt = cnt_r;
    src_nxt = src_r;
    // Only a latched read clears; unlatched reads leave flags and count alone
    if (latch_on_event && src_read) begin
      // Latched read clears flags and counter; new event needs full delay
      cnt_nxt = '0;
      src_nxt = FFMD_SRC_RESET;
      hit_now = 1'b0;
      hit_nxt = 1'b0;
    end else if (sample_valid_i) begin
      if (cond) begin
        if (cnt_r < debounce_target_i) begin
          cnt_nxt = cnt_r + 8'h01;
        end
      end else if (debounce_clear_mode_i) begin
        cnt_nxt = '0;
      end else if (cnt_r != '0) begin
        cnt_nxt = cnt_r - 8'h01;
      end
      if (latch_on_event) begin
        // Once set the hit stays; only a read drops it
        hit_nxt = hit_now | (cond && cnt_nxt >= debounce_target_i);
      end else if (debounce_clear_mode_i) begin
        hit_nxt = cond && cnt_nxt >= debounce_target_i;
      end else begin
        // Decrement mode: hit drops only when the counter has run down
        hit_nxt = (cond && cnt_nxt >= debounce_target_i) ||
                  (hit_now && cnt_nxt != '0);
      end
      src_nxt[FFMD_SRC_HIT] = hit_nxt;
      // Axis flags move only on a strobe and freeze under a latched hit;
      // the sample word is not valid between strobes, so it must not leak in
      if (!(latch_on_event && hit_now)) begin
        src_nxt[5:0] = live_flags;
      end
    end
    // Disabled axes always read zero, even if frozen before disable
    src_nxt[5:4] = src_nxt[5:4] & {2{axis_en[2]}};
    src_nxt[3:2] = src_nxt[3:2] & {2{axis_en[1]}};
    src_nxt[1:0] = src_nxt[1:0] & {2{axis_en[0]}};
    src_nxt[6]   = 1'b0;
  end

  // Interrupt: hit gated by enable, routed to one of two pins
  always_comb begin
    irq1_nxt = src_nxt[FFMD_SRC_HIT] && irq_enable_detect_i && irq_route_detect_i;
    irq2_nxt = src_nxt[FFMD_SRC_HIT] && irq_enable_detect_i && !irq_route_detect_i;
  end

  // All state registers
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      cfg_r   <= FFMD_CFG_RESET;
      src_r   <= FFMD_SRC_RESET;
      cnt_r   <= '0;
      rdata_r <= 8'h00;
      irq1_r  <= 1'b0;
      irq2_r  <= 1'b0;
    end else begin
      cfg_r   <= cfg_nxt;
      src_r   <= src_nxt;
      cnt_r   <= cnt_nxt;
      rdata_r <= rdata_nxt;
      irq1_r  <= irq1_nxt;
      irq2_r  <= irq2_nxt;
    end
  end

  assign reg_rdata_o = rdata_r;
  assign irq_pin1_o  = irq1_r;
  assign irq_pin2_o  = irq2_r;

  // Assertions
  // Nothing may fire while every axis is switched off
  a_disabled_quiet: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (cfg_r[5:3] == 3'h0 && !src_r[7] && !src_read) |=> !src_r[7])
    else $error("hit raised with all axes disabled");
  // Unused config bits must never hold a written one
  a_cfg_low_zero: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    cfg_r[2:0] == 3'h0)
    else $error("config low bits not zero");
  // A rising hit must follow a completed count
  a_hit_needs_count: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    $rose(src_r[7]) |-> cnt_r >= $past(debounce_target_i))
    else $error("hit set before debounce done");
  // Counter never climbs past the target; a lowered target only drains it
  a_cnt_saturate: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (cnt_r >= debounce_target_i && $stable(debounce_target_i)) |=>
      cnt_r <= debounce_target_i || cnt_r <= $past(cnt_r))
    else $error("counter passed target");
  // Counter moves only on a sample strobe or a latched read
  a_cnt_step: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    !sample_valid_i && !(latch_on_event && src_read) |=> $stable(cnt_r))
    else $error("counter moved without sample");
  // Latched read wipes the whole source word and the count
  a_latch_read_clr: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    (latch_on_event && src_read) |=> src_r == 8'h00 && cnt_r == '0)
    else $error("latched read did not clear");
  // A latched hit survives samples until software reads it
  a_latch_hold: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (latch_on_event && src_r[7] && !src_read && $stable(cfg_r)) |=> src_r[7])
    else $error("latched hit dropped without read");
  // Unlatched clear mode drops the hit on the first false sample
  a_fast_clear: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (!latch_on_event && debounce_clear_mode_i && sample_valid_i && !cond) |=> !src_r[7])
    else $error("hit not cleared at once");
  // X flags are masked by the enable of the cycle before
  a_axis_zero: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    !$past(axis_en[0]) |-> src_r[1:0] == 2'b00)
    else $error("disabled X axis flag set");
  // Pin 1 only with a hit, and never both pins together
  a_irq_route: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    irq_pin1_o |-> src_r[7] && !irq_pin2_o)
    else $error("irq without hit");
  // A disabled interrupt keeps both pins quiet
  a_irq_gate: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    !$past(irq_enable_detect_i) |-> !irq_pin1_o && !irq_pin2_o)
    else $error("irq while disabled");
  // Unlatched read changes neither the source word nor the count
  a_unlatched_read: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    (!latch_on_event && src_read && !sample_valid_i && $stable(cfg_r)) |=>
      $stable(src_r) && $stable(cnt_r))
    else $error("unlatched read disturbed source");
  // Between samples the source word stands still
  a_flags_idle: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (!sample_valid_i && !src_read && $stable(cfg_r)) |=> $stable(src_r))
    else $error("source changed without sample");
  // A latched hit freezes the axis flags until the read
  a_latch_freeze: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    (latch_on_event && src_r[7] && !src_read && $stable(cfg_r)) |=> $stable(src_r[5:0]))
    else $error("latched axis flags moved");
  // Decrement mode keeps the hit while the count is above one
  a_decr_hold: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (!latch_on_event && !debounce_clear_mode_i && src_r[7] && cnt_r > 8'h01) |=> src_r[7])
    else $error("decrement mode dropped hit early");
  // Clear mode empties the count on any false sample
  a_clear_zero: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (debounce_clear_mode_i && sample_valid_i && !cond) |=> cnt_r == '0)
    else $error("count not cleared");
  // Decrement mode steps the count down by exactly one
  a_decr_step: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (!debounce_clear_mode_i && sample_valid_i && !cond && cnt_r != '0 &&
      !(latch_on_event && src_read)) |=> cnt_r == $past(cnt_r) - 8'h01)
    else $error("count did not step down by one");
  // Freefall: a true condition means no enabled axis is over the level
  a_free_all: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (!any_axis_combine && cond) |-> axis_flag == 3'h0 && any_enabled)
    else $error("freefall true with an axis over level");
  // Motion: one enabled axis over the level is enough
  a_motion_any: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (any_axis_combine && axis_flag != 3'h0) |-> cond)
    else $error("motion missed an axis over level");

  // Per-axis source checks; index 0 = X, 1 = Y, 2 = Z
  for (genvar k = 0; k < FFMD_AXES; k++) begin : g_axis_chk
    // A switched-off axis never shows a flag, even a frozen one
    a_axis_off: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      !$past(axis_en[k]) |-> src_r[2*k+1 -: 2] == 2'b00)
      else $error("disabled axis flag set");
    // The sign bit stands only beside its event bit
    a_sign_pair: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      src_r[2*k] |-> src_r[2*k+1])
      else $error("sign flag without event flag");
    // Unlatched: each event bit follows the raw compare of the last sample
    a_flag_follow: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      (!latch_on_event && sample_valid_i) |=>
        src_r[2*k+1] == ($past(axis_en[k]) && $past(axis_over[k])))
      else $error("axis flag not following sample");
  end

  // Main scenarios that the bench should reach
  c_motion_hit: cover property (@(posedge clock_i) any_axis_combine ##1 $rose(src_r[7]));
  c_free_hit: cover property (@(posedge clock_i) !any_axis_combine ##1 $rose(src_r[7]));
  c_latch_read: cover property (@(posedge clock_i) latch_on_event && src_r[7] && src_read);
  c_decr_hold: cover property (@(posedge clock_i)
    !debounce_clear_mode_i && src_r[7] && sample_valid_i && !cond);
  c_all_off: cover property (@(posedge clock_i) cfg_r[5:3] == 3'h0 && sample_valid_i);

endmodule : ffmd_detector
`default_nettype wire

// ==== tb/tb_top.sv ====
// Self-checking bench for the freefall/motion event detector
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import ffmd_pkg::*;
  logic          clock_i = 1'b0;
  logic          rst_n_i = 1'b0;
  ffmd_reg_req_t req     = '0;
  ffmd_sample_t  smp_d   = '0;
  logic          vld     = 1'b0;
  logic [6:0]    lvl     = 7'h0a;
  logic          clr     = 1'b0;
  logic [7:0]    tgt     = 8'h01;
  logic          ien     = 1'b1;
  logic          rte     = 1'b1;
  logic [7:0]    rdata;
  logic          pin1;
  logic          pin2;
  int            err_count  = 0;
  int            num_checks = 0;
  // 100 MHz clock
  always #5 clock_i = ~clock_i;
  ffmd_detector uut (.clock_i(clock_i), .rst_n_i(rst_n_i), .reg_req_i(req), .reg_rdata_o(rdata),
    .sample_valid_i(vld), .sample_i(smp_d), .trip_level_i(lvl), .debounce_clear_mode_i(clr),
    .debounce_target_i(tgt), .irq_enable_detect_i(ien), .irq_route_detect_i(rte),
    .irq_pin1_o(pin1), .irq_pin2_o(pin2));
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // Inputs move 1 ns after the edge; each pulse lasts one cycle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i); #1;
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clock_i); #1;
    req.wr = 1'b0;
  endtask : wr
  task automatic rc(input logic [7:0] a, input logic [7:0] e, input string n);
    @(posedge clock_i); #1;
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clock_i); #1;
    req.rd = 1'b0;
    chk(n, e, rdata);
  endtask : rc
  task automatic smp(input int x, input int y, input int z);
    @(posedge clock_i); #1;
    smp_d = '{z: 14'(z), y: 14'(y), x: 14'(x)};
    vld = 1'b1;
    @(posedge clock_i); #1;
    vld = 1'b0;
  endtask : smp
  // Fresh reset per scenario so no debounce count leaks across
  task automatic do_reset();
    @(posedge clock_i); #1;
    rst_n_i = 1'b0;
    repeat (8) @(posedge clock_i);
    #1;
    rst_n_i = 1'b1;
  endtask : do_reset
  task automatic t_regs();
    do_reset();
    rc(FFMD_ADDR_CONFIG, FFMD_CFG_RESET, "cfg reset");
    wr(FFMD_ADDR_CONFIG, 8'hff);
    rc(FFMD_ADDR_CONFIG, 8'hf8, "cfg rw");
    wr(FFMD_ADDR_SOURCE, 8'hff);
    rc(FFMD_ADDR_SOURCE, 8'h00, "src ro");
    rc(8'h20, 8'h00, "unmapped");
    wr(FFMD_ADDR_CONFIG, 8'hc0);
    smp(700, 700, 700);
    rc(FFMD_ADDR_SOURCE, 8'h00, "all off");
    chk("irq off", 8'h00, {7'h0, pin1});
  endtask : t_regs
  task automatic t_motion();
    do_reset();
    tgt = 8'h02;
    clr = 1'b1;
    rte = 1'b1;
    wr(FFMD_ADDR_CONFIG, 8'h48);
    @(posedge clock_i); #1;
    smp_d = '{z: 14'sd0, y: 14'sd0, x: -14'sd700};
    repeat (3) @(posedge clock_i);
    rc(FFMD_ADDR_SOURCE, 8'h00, "no strobe");
    smp(0, -700, 0);
    rc(FFMD_ADDR_SOURCE, 8'h00, "y disabled");
    smp(-700, 0, 0);
    rc(FFMD_ADDR_SOURCE, 8'h03, "count 1");
    smp(-700, 0, 0);
    rc(FFMD_ADDR_SOURCE, 8'h83, "motion hit");
    chk("pins", 8'h01, {6'h0, pin2, pin1});
    rc(FFMD_ADDR_SOURCE, 8'h83, "read keeps");
    smp(640, 0, 0);
    rc(FFMD_ADDR_SOURCE, 8'h00, "boundary");
    smp(641, 0, 0);
    rc(FFMD_ADDR_SOURCE, 8'h02, "refire wait");
  endtask : t_motion
  task automatic t_decr();
    do_reset();
    tgt = 8'h03;
    clr = 1'b0;
    wr(FFMD_ADDR_CONFIG, 8'h48);
    repeat (3) smp(700, 0, 0);
    rc(FFMD_ADDR_SOURCE, 8'h82, "hit at 3");
    smp(0, 0, 0);
    rc(FFMD_ADDR_SOURCE, 8'h80, "decrement");
  endtask : t_decr
  task automatic t_ff();
    do_reset();
    tgt = 8'h01;
    clr = 1'b1;
    wr(FFMD_ADDR_CONFIG, 8'h38);
    smp(100, 100, 700);
    rc(FFMD_ADDR_SOURCE, 8'h20, "ff and");
    smp(100, -100, 0);
    rc(FFMD_ADDR_SOURCE, 8'h80, "ff hit");
    rc(FFMD_ADDR_SOURCE, 8'h80, "ff read");
    do_reset();
    tgt = 8'h02;
    wr(FFMD_ADDR_CONFIG, 8'hb8);
    repeat (2) smp(0, 0, 0);
    smp(700, 0, 0);
    rc(FFMD_ADDR_SOURCE, 8'h80, "ff latch");
    rc(FFMD_ADDR_SOURCE, 8'h00, "ff cleared");
    smp(0, 0, 0);
    rc(FFMD_ADDR_SOURCE, 8'h00, "ff recount");
  endtask : t_ff
  task automatic t_mlat();
    do_reset();
    tgt = 8'h01;
    rte = 1'b0;
    wr(FFMD_ADDR_CONFIG, 8'hc8);
    smp(-700, 0, 0);
    smp(700, 0, 0);
    smp(0, 0, 0);
    chk("pin2", 8'h02, {6'h0, pin2, pin1});
    // Dropping the enable must silence both pins one edge later
    ien = 1'b0;
    @(posedge clock_i);
    #1;
    chk("irq gated", 8'h00, {6'h0, pin2, pin1});
    ien = 1'b1;
    rc(FFMD_ADDR_SOURCE, 8'h83, "m latch");
    rc(FFMD_ADDR_SOURCE, 8'h00, "m cleared");
    chk("pins low", 8'h00, {6'h0, pin2, pin1});
  endtask : t_mlat
  task automatic summarize();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : summarize
  // Watchdog at 20000 cycles, well beyond the roughly 160 cycles the scenarios need
  initial begin
    #200000;
    err_count++;
    summarize();
  end
  initial begin
    t_regs();
    t_motion();
    t_decr();
    t_ff();
    t_mlat();
    summarize();
  end
endmodule : tb_top
`default_nettype wire
